// File: ipc_pkg.sv
package ipc_pkg;
  // Switch and error constants
  localparam logic [7:0]  IPC_SW_NVM      = 8'h00;
  localparam logic [7:0]  IPC_SW_RANGE    = 8'hFF;
  localparam logic [4:0]  IPC_HIGH_WEIGHT = 5'h10;
  localparam logic [15:0] IPC_ERR_NONE    = 16'h0000;
  localparam logic [15:0] IPC_ERR_RANGE   = 16'h2400;
  localparam logic [15:0] IPC_ERR_CHANGED = 16'h1030;
  localparam logic [31:0] IPC_FIXED_IP    = 32'hC0A803FA;
  localparam logic [31:0] IPC_FIXED_MASK  = 32'hFFFFFF00;
  localparam logic [31:0] IPC_NVM_DEFAULT = 32'hC0A803FA;
  localparam logic [31:0] IPC_IP_MIN      = 32'h00000001;
  localparam logic [31:0] IPC_IP_MAX      = 32'hDFFFFFFE;
  localparam logic [15:0] IPC_LOW16_ONES  = 16'hFFFF;
  // Flash divider: 250 ms half period at 100 MHz
  localparam int          IPC_CLK_MHZ     = 100;
  localparam int          IPC_FLASH_MS    = 250;
  localparam int          IPC_FLASH_CYC   = IPC_FLASH_MS * 1000 * IPC_CLK_MHZ;

  // Address and mask pair
  typedef struct packed {
    logic [31:0] ip;
    logic [31:0] mask;
  } ipc_addr_t;

  // Source selection states
  typedef enum logic [2:0] {
    IPC_SRC_SWITCH = 3'b001,
    IPC_SRC_NVM    = 3'b010,
    IPC_SRC_FIXED  = 3'b100
  } ipc_src_t;
endpackage

// File: ipc_check.sv
`timescale 1ns/1ps
`default_nettype none
module ipc_check
  import ipc_pkg::*;
(
  input  wire ipc_addr_t addr_in,     // Address and mask under test
  output logic           ip_ok_out,   // Address usable
  output logic           mask_ok_out  // Mask usable
);
  logic [31:0] host;
  logic [31:0] inv;

  // Legality of address against mask
  always_comb begin
    host = addr_in.ip & ~addr_in.mask;
    inv  = ~addr_in.mask;
    ip_ok_out = (host != 32'h0) && (host != inv)                 // RULE_09
      && (addr_in.ip[15:0] != IPC_LOW16_ONES)                    // RULE_09
      && (addr_in.ip >= IPC_IP_MIN) && (addr_in.ip <= IPC_IP_MAX); // RULE_09
    // Contiguous ones then zeros: inverse plus one is a power of two
    mask_ok_out = (addr_in.mask != 32'h0)                        // RULE_10
      && (((inv + 32'h1) & inv) == 32'h0);                       // RULE_10
  end
endmodule
`default_nettype wire

// File: ipc_config.sv
// Behaviour
// [RULE_01] Fourth octet is high digit times sixteen plus low digit.
// [RULE_02] Switch 1..254 takes octets one to three and mask from master.
// [RULE_03] Switch 0 uses the stored address with the master mask.
// [RULE_04] Switch 255 reports 2400H and uses 192.168.3.250/255.255.255.0.
// [RULE_05] A switch change while running reports 1030H and flashes the LED.
// [RULE_06] Restoring the switch then toggling reset request clears the error.
// [RULE_07] Switch 1..254 address is stored once the data link is up.
// [RULE_08] Stored address defaults to 192.168.3.250.
// [RULE_09] Addresses with bad host part or out of range are unusable.
// [RULE_10] Zero or non-contiguous masks are unusable.
// [RULE_11] Switch is latched once after reset and compared continuously.
`timescale 1ns/1ps
`default_nettype none
module ipc_config
  import ipc_pkg::*;
(
  input  wire logic        ref_clk_in,               // 100 MHz clock
  input  wire logic        rst_n_in,                 // Async reset, low
  input  wire logic [3:0]  ip_switch_high_digit_in,  // High switch digit pin
  input  wire logic [3:0]  ip_switch_low_digit_in,   // Low switch digit pin
  input  wire ipc_addr_t   master_addr_in,           // Master ip and mask
  input  wire logic        link_up_in,               // Data link established
  input  wire logic        error_reset_request_in,   // Error reset request
  output ipc_addr_t        addr_out,                 // Operating ip and mask
  output logic             addr_valid_out,           // Address and mask usable
  output logic [15:0]      error_code_out,           // Active error code
  output logic             error_led_out,            // Error indicator
  output logic [31:0]      nvm_ip_out,               // Stored address
  output logic             nvm_write_out             // Store pulse
);
  logic [7:0]  sw_s1, sw_s2, next_sw_s1, next_sw_s2;
  logic        rr_s1, rr_s2, rr_d, next_rr_s1, next_rr_s2, next_rr_d;
  logic        link_s1, link_s2, next_link_s1, next_link_s2;
  logic        latched, next_latched;
  logic [1:0]  arm, next_arm;
  logic [7:0]  sw_val, next_sw_val;
  ipc_src_t    src, next_src;
  logic        changed, next_changed;
  logic        stored, next_stored;
  logic [31:0] nvm_ip, next_nvm_ip;
  logic        nvm_wr, next_nvm_wr;
  ipc_addr_t   addr, next_addr;
  logic [15:0] err, next_err;
  logic [31:0] flash_cnt, next_flash_cnt;
  logic        flash, next_flash;
  logic        led, next_led;
  logic        valid, next_valid;
  logic [7:0]  live_sw;
  logic        ip_ok, mask_ok;

  ipc_check u_check (
    .addr_in     (addr),
    .ip_ok_out   (ip_ok),
    .mask_ok_out (mask_ok)
  );

  // Combine the two synchronised switch digits
  always_comb begin
    live_sw = 8'({4'h0, sw_s2[7:4]} * IPC_HIGH_WEIGHT) // RULE_01
            + {4'h0, sw_s2[3:0]};                      // RULE_01
  end

  // Next state of synchronisers, latch, address, errors and indicator
  always_comb begin
    next_sw_s1   = {ip_switch_high_digit_in, ip_switch_low_digit_in};
    next_sw_s2   = sw_s1;
    next_rr_s1   = error_reset_request_in;
    next_rr_s2   = rr_s1;
    next_rr_d    = rr_s2;
    next_link_s1 = link_up_in;
    next_link_s2 = link_s1;
    next_arm     = {arm[0], 1'b1};
    next_latched = arm[1];
    next_sw_val  = sw_val;
    next_src     = src;
    next_changed = changed;
    next_stored  = stored;
    next_nvm_ip  = nvm_ip;
    next_nvm_wr  = 1'b0;
    next_addr    = addr;
    next_err     = IPC_ERR_NONE;
    next_flash_cnt = flash_cnt;
    next_flash   = flash;
    next_valid   = ip_ok && mask_ok;                             // RULE_09
    // Latch only once both synchroniser stages hold pin values
    if (!latched && arm[1]) begin
      next_sw_val = live_sw;                                     // RULE_11
      if (live_sw == IPC_SW_NVM) begin
        next_src = IPC_SRC_NVM;
      end else if (live_sw == IPC_SW_RANGE) begin
        next_src = IPC_SRC_FIXED;
      end else begin
        next_src = IPC_SRC_SWITCH;
      end
    end
    // Address from the latched source only, nothing shown before it
    if (latched) begin
      unique case (src)
        IPC_SRC_SWITCH: begin
          next_addr.ip   = {master_addr_in.ip[31:8], sw_val};    // RULE_02
          next_addr.mask = master_addr_in.mask;                  // RULE_02
        end
        IPC_SRC_NVM: begin
          next_addr.ip   = nvm_ip;                               // RULE_03
          next_addr.mask = master_addr_in.mask;                  // RULE_03
        end
        IPC_SRC_FIXED: begin
          next_addr.ip   = IPC_FIXED_IP;                         // RULE_04
          next_addr.mask = IPC_FIXED_MASK;                       // RULE_04
        end
      endcase
    end
    // Change detection and recovery on reset request rising edge
    if (latched && (live_sw != sw_val)) begin
      next_changed = 1'b1;                                       // RULE_05
    end else if (changed && rr_s2 && !rr_d) begin
      next_changed = 1'b0;                                       // RULE_06
    end
    // Store address once the link is up
    if (latched && src == IPC_SRC_SWITCH && link_s2 && !stored) begin
      next_nvm_ip = next_addr.ip;                                // RULE_07
      next_nvm_wr = 1'b1;                                        // RULE_07
      next_stored = 1'b1;
    end
    if (changed) begin
      next_err = IPC_ERR_CHANGED;                                // RULE_05
    end else if (src == IPC_SRC_FIXED) begin
      next_err = IPC_ERR_RANGE;                                  // RULE_04
    end
    // Flash timebase
    if (flash_cnt >= 32'(IPC_FLASH_CYC - 1)) begin
      next_flash_cnt = 32'h0;
      next_flash     = !flash;
    end else begin
      next_flash_cnt = flash_cnt + 32'h1;
    end
    next_led = changed ? flash                                   // RULE_05
                       : (src == IPC_SRC_FIXED);
  end

  // Register stage
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sw_s1     <= 8'h00;
      sw_s2     <= 8'h00;
      rr_s1     <= 1'b0;
      rr_s2     <= 1'b0;
      rr_d      <= 1'b0;
      link_s1   <= 1'b0;
      link_s2   <= 1'b0;
      latched   <= 1'b0;
      arm       <= 2'h0;
      sw_val    <= 8'h00;
      src       <= IPC_SRC_NVM;
      changed   <= 1'b0;
      stored    <= 1'b0;
      nvm_ip    <= IPC_NVM_DEFAULT;                              // RULE_08
      nvm_wr    <= 1'b0;
      addr      <= '0;
      err       <= IPC_ERR_NONE;
      flash_cnt <= 32'h0;
      flash     <= 1'b0;
      led       <= 1'b0;
      valid     <= 1'b0;
    end else begin
      sw_s1     <= next_sw_s1;
      sw_s2     <= next_sw_s2;
      rr_s1     <= next_rr_s1;
      rr_s2     <= next_rr_s2;
      rr_d      <= next_rr_d;
      link_s1   <= next_link_s1;
      link_s2   <= next_link_s2;
      latched   <= next_latched;
      arm       <= next_arm;
      sw_val    <= next_sw_val;
      src       <= next_src;
      changed   <= next_changed;
      stored    <= next_stored;
      nvm_ip    <= next_nvm_ip;
      nvm_wr    <= next_nvm_wr;
      addr      <= next_addr;
      err       <= next_err;
      flash_cnt <= next_flash_cnt;
      flash     <= next_flash;
      led       <= next_led;
      valid     <= next_valid;
    end
  end

  assign addr_out       = addr;
  assign addr_valid_out = valid;
  assign error_code_out = err;
  assign error_led_out  = led;
  assign nvm_ip_out     = nvm_ip;
  assign nvm_write_out  = nvm_wr;

  // Checks
  AST_FIXED_ADDR: assert property ( // RULE_04
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    src == IPC_SRC_FIXED |=> addr.ip == IPC_FIXED_IP
      && addr.mask == IPC_FIXED_MASK)
    else $error("fixed address not applied");
  AST_RANGE_CODE: assert property ( // RULE_04
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    src == IPC_SRC_FIXED && !changed |=> err == IPC_ERR_RANGE)
    else $error("range error code missing");
  AST_SWITCH_ADDR: assert property ( // RULE_02
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    src == IPC_SRC_SWITCH |=> addr.ip == {$past(master_addr_in.ip[31:8]),
      sw_val})
    else $error("switch address wrong");
  AST_NVM_ADDR: assert property ( // RULE_03
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    latched && src == IPC_SRC_NVM |=> addr.mask == $past(master_addr_in.mask))
    else $error("stored mode mask wrong");
  AST_CHANGE: assert property ( // RULE_05
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    latched && live_sw != sw_val |=> ##1 err == IPC_ERR_CHANGED)
    else $error("change error not raised");
  AST_CHANGE_LED: assert property ( // RULE_05
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    changed |=> led == $past(flash))
    else $error("indicator not following flash timebase");
  AST_FLASH_TOGGLE: assert property ( // RULE_05
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    flash_cnt >= 32'(IPC_FLASH_CYC - 1) |=> flash != $past(flash))
    else $error("flash timebase did not toggle");
  AST_RECOVER: assert property ( // RULE_06
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    changed && live_sw == sw_val && rr_s2 && !rr_d |=> !changed)
    else $error("recovery failed");
  AST_STORE_ONCE: assert property ( // RULE_07
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    nvm_wr |=> !nvm_wr [*8])
    else $error("repeated store");
  AST_STORE_SRC: assert property ( // RULE_07
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    nvm_wr |-> src == IPC_SRC_SWITCH && nvm_ip == addr.ip)
    else $error("store from wrong source or value");
  AST_LATCH_HOLD: assert property ( // RULE_11
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    latched && $past(latched) |-> $stable(sw_val) && $stable(src))
    else $error("latched switch moved");
  AST_EARLY_QUIET: assert property ( // RULE_11
    @(posedge ref_clk_in) disable iff (!rst_n_in)
    !latched |=> addr == '0)
    else $error("address shown before switch latched");
endmodule
`default_nettype wire

// File: ipc_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module ipc_master_model
  import ipc_pkg::*;
#(
  parameter int LINK_DLY = 4
) (
  input  wire logic      ref_clk_in,      // 100 MHz clock
  input  wire logic      rst_n_in,        // Async reset, low
  input  wire ipc_addr_t cfg_in,          // Station ip and mask
  input  wire logic      link_en_in,      // Start data link
  input  wire logic      clr_in,          // Operator reset command
  output ipc_addr_t      master_addr_out, // Own ip and mask
  output logic           link_up_out,     // Data link up
  output logic           clr_req_out      // Error reset request
);
  int cnt;
  // Own address offered at all times
  assign master_addr_out = cfg_in;
  // Link rises a fixed delay after start; request follows command
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt         <= 0;
      link_up_out <= 1'b0;
      clr_req_out <= 1'b0;
    end else begin
      cnt         <= link_en_in ? cnt + 1 : 0;
      link_up_out <= link_en_in && (cnt >= LINK_DLY);
      clr_req_out <= clr_in;
    end
  end
endmodule
`default_nettype wire

// File: test_ip_octet_switch_config.sv
`timescale 1ns/1ps
`default_nettype none
module test_ip_octet_switch_config
  import ipc_pkg::*;
;
  typedef struct packed {
    logic [7:0]  sw;
    ipc_addr_t   m;
    ipc_addr_t   e;
    logic [15:0] err;
    logic        v;
  } ipc_row_t;
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic [3:0]  hi      = 4'h0;
  logic [3:0]  lo      = 4'h0;
  ipc_addr_t   cfg     = 64'h0;
  logic        link_en = 1'b0;
  logic        clr     = 1'b0;
  ipc_addr_t   m_addr, addr;
  logic        link_up, clr_req, valid, led, nvm_wr;
  logic [15:0] err_code;
  logic [31:0] nvm_ip;
  int          n_errors        = 0;
  int          samples_checked = 0;
  int          n;
  // Ordinary cases: switch, master pair, expected pair, code, usable
  ipc_row_t rows [10] = '{
    {8'h1E, 64'hC0A80A05FFFFFF00, 64'hC0A80A1EFFFFFF00, 16'h0000, 1'b1},
    {8'h01, 64'h0A000063FF000000, 64'h0A000001FF000000, 16'h0000, 1'b1},
    {8'hFE, 64'hC0A80A05FFFFFF00, 64'hC0A80AFEFFFFFF00, 16'h0000, 1'b1},
    {8'h00, 64'hC0A80A05FFFF0000, 64'hC0A803FAFFFF0000, 16'h0000, 1'b1},
    {8'hFF, 64'hC0A80A05FFFF0000, 64'hC0A803FAFFFFFF00, 16'h2400, 1'b1},
    {8'h10, 64'hC0A80A05FFFF00FF, 64'hC0A80A10FFFF00FF, 16'h0000, 1'b0},
    {8'h10, 64'hC0A80A0500000000, 64'hC0A80A1000000000, 16'h0000, 1'b0},
    {8'h05, 64'hE0000001FFFFFF00, 64'hE0000005FFFFFF00, 16'h0000, 1'b0},
    {8'h7F, 64'hC0A80A05FFFFFF80, 64'hC0A80A7FFFFFFF80, 16'h0000, 1'b0},
    {8'h80, 64'hC0A80A05FFFFFF80, 64'hC0A80A80FFFFFF80, 16'h0000, 1'b0}};

  always #5 ref_clk = ~ref_clk;

  ipc_master_model u_master (
    .ref_clk_in(ref_clk), .rst_n_in(rst_n), .cfg_in(cfg),
    .link_en_in(link_en), .clr_in(clr), .master_addr_out(m_addr),
    .link_up_out(link_up), .clr_req_out(clr_req));

  ipc_config uut (
    .ref_clk_in(ref_clk), .rst_n_in(rst_n),
    .ip_switch_high_digit_in(hi), .ip_switch_low_digit_in(lo),
    .master_addr_in(m_addr), .link_up_in(link_up),
    .error_reset_request_in(clr_req), .addr_out(addr),
    .addr_valid_out(valid), .error_code_out(err_code),
    .error_led_out(led), .nvm_ip_out(nvm_ip), .nvm_write_out(nvm_wr));

  // Compare and count
  task automatic chk(input string nm, input logic [63:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Reset with switch set, then settle
  task automatic pwr(input logic [7:0] sw);
    rst_n <= 1'b0;
    {hi, lo} <= sw;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask

  // Bring link up and count store pulses
  task automatic store(input logic [7:0] sw, input logic [31:0] ip, int w);
    link_en <= 1'b0;
    pwr(sw);
    link_en <= 1'b1;
    n = 0;
    repeat (14) begin
      @(posedge ref_clk);
      #1 n += int'(nvm_wr);
    end
    chk("nvm_ip", 64'(nvm_ip), 64'(ip));
    chk("writes", 64'(n), 64'(w));
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    @(posedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      cfg <= rows[i].m;
      pwr(rows[i].sw);
      chk("addr", addr, rows[i].e);
      chk("code", 64'(err_code), 64'(rows[i].err));
      chk("valid", 64'(valid), 64'(rows[i].v));
      chk("led", 64'(led), 64'(rows[i].err == 16'h2400));
    end
    // Outputs while held in reset
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("rst_nvm", 64'(nvm_ip), 64'h00000000C0A803FA);
    chk("rst_addr", addr, 64'h0);
    chk("rst_code", 64'(err_code), 64'h0);
    chk("rst_wr", 64'(nvm_wr), 64'h0);
    // First two edges after release show nothing before the latch
    rst_n <= 1'b1;
    repeat (2) begin
      @(posedge ref_clk);
      #1 chk("rel_addr", addr, 64'h0);
      chk("rel_valid", 64'(valid), 64'h0);
    end
    @(posedge ref_clk);
    cfg <= rows[0].m;
    store(8'h1E, 32'hC0A80A1E, 1);
    store(8'h00, 32'hC0A803FA, 0);
    // Live change, refused recovery, then proper recovery
    pwr(8'h1E);
    lo <= 4'hF;
    repeat (6) @(posedge ref_clk);
    chk("chg_code", 64'(err_code), 64'h1030);
    chk("chg_addr", addr, rows[0].e);
    clr <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("refused", 64'(err_code), 64'h1030);
    lo <= 4'hE;
    clr <= 1'b0;
    repeat (5) @(posedge ref_clk);
    clr <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("rec_code", 64'(err_code), 64'h0);
    chk("rec_led", 64'(led), 64'h0);
    stop_test();
  end

  // Watchdog
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
